// ---- logic/bfp_top.sv ----
// breaker failure pick-up, timers, status and apb registers
`timescale 1ns/100ps
module bfp_top
  import bfp_pkg::*;
#(
  parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [AW-1:0]         i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic [2:0][MAG_W-1:0] i_phase_mag,
  input  wire logic [MAG_W-1:0]      i_residual_input_one,
  input  wire logic [MAG_W-1:0]      i_residual_input_two,
  input  wire logic [MAG_W-1:0]      i_derived_residual_current,
  input  wire logic [SIG_W-1:0]      i_trip_signals,
  input  wire logic [DO_W-1:0]       i_relay_ctrl,
  input  wire logic                  i_block,
  input  wire logic                  i_group_sel,
  output logic                       o_start,
  output logic                       o_retrip,
  output logic                       o_breaker_failure_output,
  output logic                       o_blocked,
  output bfp_state_t                 o_status
);

  localparam int CYC_W = (P_STEP_CYCLES > 1) ? $clog2(P_STEP_CYCLES) : 1;

  bfp_ctrl_t        ctrl;
  bfp_grp_t         grp [2];
  bfp_grp_t         act;
  logic [SIG_W-1:0] sig_mask;
  logic [DO_W-1:0]  do_mask;
  logic [CYC_W-1:0] cyc;
  logic [DLY_W-1:0] steps;
  logic             gsel;
  logic [2:0]       ph_pick;
  logic             res_pick;
  logic             res_en;
  logic [MAG_W-1:0] res_mag;
  logic [MAG_W-1:0] ph_thr_milli;
  logic             cur_act;
  logic             sig_act;
  logic             do_act;
  logic [2:0]       crit_act;
  logic [2:0]       crit_sel;
  logic             pickup;
  logic             run;
  logic             rt_hit;
  logic             bf_hit;
  bfp_state_t       next_state;
  bfp_state_t       shown;
  logic             setup;
  logic             wr_fire;
  logic             rd_hit;
  logic [31:0]      rd_word;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign setup   = i_psel && !i_penable;
  assign wr_fire = i_psel && i_penable && o_pready && i_pwrite;

  always_comb begin
    rd_word = '0;
    rd_hit  = (i_paddr[1:0] == 2'h0);
    if (i_paddr[7:5] == GRP_PAGE) begin
      case (i_paddr[3:2])
        FLD_PH_THR:  rd_word = 32'(grp[i_paddr[4]].phase_pickup_threshold);
        FLD_RES_THR: rd_word = 32'(grp[i_paddr[4]].residual_pickup_threshold);
        FLD_RT_DLY:  rd_word = 32'(grp[i_paddr[4]].rt_dly);
        default:     rd_word = 32'(grp[i_paddr[4]].bf_dly);
      endcase
    end else begin
      case (i_paddr)
        OFS_CTRL:     rd_word = 32'(ctrl);
        OFS_SIG_MASK: rd_word = 32'(sig_mask);
        OFS_DO_MASK:  rd_word = 32'(do_mask);
        OFS_STATUS:   rd_word = {19'h0, i_block, do_act, sig_act, cur_act,
                                 pickup, 3'h0, o_status};
        OFS_TIMER:    rd_word = 32'(steps);
        default:      rd_hit  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !rd_hit;
      if (setup) begin
        o_prdata <= (rd_hit && !i_pwrite) ? rd_word : '0;
      end
    end
  end

  // RULE15 mode and control
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RST;
    end else if (wr_fire && i_paddr == OFS_CTRL) begin
      ctrl <= bfp_ctrl_t'(i_pwdata[CTRL_W-1:0]);
    end
  end

  // RULE10 masks outside groups
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sig_mask <= '0;
      do_mask  <= '0;
    end else if (wr_fire && i_paddr == OFS_SIG_MASK) begin
      sig_mask <= i_pwdata[SIG_W-1:0];
    end else if (wr_fire && i_paddr == OFS_DO_MASK) begin
      do_mask <= i_pwdata[DO_W-1:0];
    end
  end

  // RULE16 RULE17 group defaults
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      grp[0] <= GRP_RST;
      grp[1] <= GRP_RST;
    end else if (wr_fire && i_paddr[7:5] == GRP_PAGE && i_paddr[1:0] == 2'h0) begin
      case (i_paddr[3:2])
        FLD_PH_THR:  grp[i_paddr[4]].phase_pickup_threshold <= i_pwdata[MAG_W-1:0];
        FLD_RES_THR: grp[i_paddr[4]].residual_pickup_threshold <= i_pwdata[MAG_W-1:0];
        FLD_RT_DLY:  grp[i_paddr[4]].rt_dly <= i_pwdata[DLY_W-1:0];
        default:     grp[i_paddr[4]].bf_dly <= i_pwdata[DLY_W-1:0];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // current criterion
  // ---------------------------------------------------------------
  // RULE14 live group swap
  assign gsel = ctrl.group_sel | i_group_sel;
  assign act  = grp[gsel];

  // RULE16 centi to milli scale
  assign ph_thr_milli = MAG_W'(32'(act.phase_pickup_threshold) * PHASE_SCALE);

  // RULE6 RULE7 residual source
  always_comb begin
    res_en  = 1'b1;
    res_mag = '0;
    case (ctrl.res_sel)
      RES_INPUT_ONE: res_mag = i_residual_input_one;
      RES_INPUT_TWO: res_mag = i_residual_input_two;
      RES_DERIVED:   res_mag = i_derived_residual_current;
      default:       res_en  = 1'b0;
    endcase
  end

  // RULE3 three phases compared
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      bfp_level_cmp #(.W(MAG_W)) u_ph (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_enable  (1'b1),
        .i_mag     (i_phase_mag[gi]),
        .i_thr     (ph_thr_milli),
        .o_pick    (ph_pick[gi])
      );
    end
  endgenerate

  // RULE3 selected residual compared
  bfp_level_cmp #(.W(MAG_W)) u_res (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_enable  (res_en),
    .i_mag     (res_mag),
    .i_thr     (act.residual_pickup_threshold),
    .o_pick    (res_pick)
  );

  // ---------------------------------------------------------------
  // criteria combination
  // ---------------------------------------------------------------
  // RULE12 any phase or residual
  assign cur_act = (|ph_pick) | res_pick;
  // RULE4 RULE8 masked signals
  assign sig_act = |(i_trip_signals & sig_mask);
  // RULE5 RULE9 masked relays
  assign do_act  = |(i_relay_ctrl & do_mask);

  // RULE2 RULE22 and or combine
  assign crit_act = {do_act, sig_act, cur_act};
  assign crit_sel = ctrl.mode[MODE_DO:MODE_CUR];
  assign pickup   = ctrl.mode[MODE_AND] ?
                    ((&(crit_act | ~crit_sel)) && (|crit_sel)) :
                    (|(crit_act & crit_sel));

  // RULE21 block suppresses timing
  assign run = pickup && !i_block;

  // ---------------------------------------------------------------
  // delay timers
  // ---------------------------------------------------------------
  // RULE18 RULE19 RULE20 shared step timer
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || !run) begin
      cyc   <= '0;
      steps <= '0;
    end else if (cyc == CYC_W'(P_STEP_CYCLES - 1)) begin
      cyc <= '0;
      if (steps != DLY_MAX) begin
        steps <= steps + 1'b1;
      end
    end else begin
      cyc <= cyc + 1'b1;
    end
  end

  assign rt_hit = run && steps >= act.rt_dly;
  assign bf_hit = run && steps >= act.bf_dly;

  // ---------------------------------------------------------------
  // status and outputs
  // ---------------------------------------------------------------
  always_comb begin
    if (!pickup) begin
      next_state = ST_NORMAL;
    // RULE21 blocked status
    end else if (i_block) begin
      next_state = ST_BLOCKED;
    end else if (bf_hit) begin
      next_state = ST_BFAIL;
    end else if (rt_hit && ctrl.retrip_en) begin
      next_state = ST_RETRIP;
    end else begin
      next_state = ST_START;
    end
  end

  // RULE11 forced status
  always_comb begin
    shown = next_state;
    if (ctrl.force_en) begin
      case (ctrl.force_code)
        FORCE_START:   shown = ST_START;
        FORCE_RETRIP:  shown = ST_RETRIP;
        FORCE_BFAIL:   shown = ST_BFAIL;
        FORCE_BLOCKED: shown = ST_BLOCKED;
        default:       shown = ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_status                 <= ST_NORMAL;
      o_start                  <= 1'b0;
      o_blocked                <= 1'b0;
      o_retrip                 <= 1'b0;
      o_breaker_failure_output <= 1'b0;
    end else begin
      o_status  <= shown;
      o_start   <= shown inside {ST_START, ST_RETRIP, ST_BFAIL};
      o_blocked <= shown == ST_BLOCKED;
      // RULE1 retrip gated by enable
      o_retrip  <= ctrl.retrip_en &&
                   (ctrl.force_en ? shown == ST_RETRIP : rt_hit);
      o_breaker_failure_output <= shown == ST_BFAIL;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  property p_rt_off;
    !ctrl.retrip_en |=> !o_retrip;
  endproperty
  a_rt_off: assert property (p_rt_off) else $error("retrip while disabled"); // RULE1

  property p_sig_mask;
    ctrl.mode == MODE_SIG_ONLY && (i_trip_signals & sig_mask) == '0 |-> !pickup;
  endproperty
  a_sig_mask: assert property (p_sig_mask) else $error("unmasked signal pick-up"); // RULE8

  property p_do_mask;
    ctrl.mode == MODE_DO_ONLY |-> pickup == do_act;
  endproperty
  a_do_mask: assert property (p_do_mask) else $error("relay pick-up mismatch"); // RULE9

  property p_force_blk;
    ctrl.force_en && ctrl.force_code == FORCE_BLOCKED |=> o_status == ST_BLOCKED;
  endproperty
  a_force_blk: assert property (p_force_blk) else $error("force ignored"); // RULE11

  property p_rt_time;
    $rose(o_retrip) && !$past(ctrl.force_en) |-> $past(steps) >= $past(act.rt_dly);
  endproperty
  a_rt_time: assert property (p_rt_time) else $error("retrip too early"); // RULE18

  property p_bf_time;
    $rose(o_breaker_failure_output) && !$past(ctrl.force_en)
      |-> $past(steps) >= $past(act.bf_dly) && $past(run);
  endproperty
  a_bf_time: assert property (p_bf_time) else $error("failure output too early"); // RULE19

  property p_release;
    !pickup && !ctrl.force_en |=> steps == '0 && !o_retrip && o_status == ST_NORMAL;
  endproperty
  a_release: assert property (p_release) else $error("timers not cleared"); // RULE20

  property p_block;
    pickup && i_block && !ctrl.force_en |=> o_blocked && !o_start && steps == '0;
  endproperty
  a_block: assert property (p_block) else $error("block not honoured"); // RULE21

  property p_and_mode;
    ctrl.mode[MODE_AND] && (crit_sel & ~crit_act) != 3'h0 |-> !pickup;
  endproperty
  a_and_mode: assert property (p_and_mode) else $error("and mode picked early"); // RULE22

  c_retrip:  cover property ($rose(o_retrip));
  c_bfail:   cover property ($rose(o_breaker_failure_output));
  c_blocked: cover property (o_start ##1 o_blocked);

endmodule : bfp_top

// ---- pkg/bfp_pkg.sv ----
// constants, types and register map of the breaker failure pick-up stage
//
// Contract
// RULE1: retrip output can be disabled by setting
// RULE2: triggers: current, outputs, signals, any mix
// RULE3: current mode watches three phases plus residual
// RULE4: any internal binary signal may trigger
// RULE5: output mode watches chosen relay control
// RULE6: fundamental magnitudes; residual from one, two, derived
// RULE7: residual selector default not in use
// RULE8: signal mask acts only in signal modes
// RULE9: output mask acts only in output modes
// RULE10: masks and forcing ignore setting groups
// RULE11: forcing overrides reported status, default normal
// RULE12: pick-up when any phase or residual exceeds
// RULE13: release below 97 percent of threshold
// RULE14: setting group swaps pick-up parameters live
// RULE15: mode selector, default current only
// RULE16: phase threshold 0.01 steps, default 0.20
// RULE17: residual threshold 0.001 steps, default 1.200
// RULE18: retrip after delay, 5 ms step, 100 ms
// RULE19: failure output after own delay, 200 ms
// RULE20: timers clear when pick-up releases
// RULE21: block reports blocked and resets timing
// RULE22: and needs all criteria, or any one
package bfp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned STEP_MS     = 5;
  localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned RT_DLY_MS   = 100;
  localparam int unsigned BF_DLY_MS   = 200;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int MAG_W = 16;
  localparam int DLY_W = 20;
  localparam int SIG_W = 16;
  localparam int DO_W  = 8;
  localparam int AW    = 8;
  localparam int CTRL_W = 12;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_SIG_MASK = 8'h04;
  localparam logic [AW-1:0] OFS_DO_MASK  = 8'h08;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h0c;
  localparam logic [AW-1:0] OFS_TIMER    = 8'h10;
  localparam logic [2:0]    GRP_PAGE     = 3'h1;
  localparam logic [1:0]    FLD_PH_THR   = 2'h0;
  localparam logic [1:0]    FLD_RES_THR  = 2'h1;
  localparam logic [1:0]    FLD_RT_DLY   = 2'h2;
  localparam logic [1:0]    FLD_BF_DLY   = 2'h3;

  // ---------------------------------------------------------------
  // scaling and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PHASE_SCALE = 10;
  localparam int unsigned HYST_NUM    = 97;
  localparam int unsigned HYST_DEN    = 100;
  localparam logic [MAG_W-1:0] PH_THR_RST  = 16'h0014;
  localparam logic [MAG_W-1:0] RES_THR_RST = 16'h04b0;
  localparam logic [DLY_W-1:0] RT_DLY_RST  = DLY_W'(RT_DLY_MS / STEP_MS);
  localparam logic [DLY_W-1:0] BF_DLY_RST  = DLY_W'(BF_DLY_MS / STEP_MS);
  localparam logic [DLY_W-1:0] DLY_MAX     = 20'hfffff;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  localparam int MODE_CUR = 0;
  localparam int MODE_SIG = 1;
  localparam int MODE_DO  = 2;
  localparam int MODE_AND = 3;
  localparam logic [3:0] MODE_CUR_ONLY = 4'h1;
  localparam logic [3:0] MODE_SIG_ONLY = 4'h2;
  localparam logic [3:0] MODE_DO_ONLY  = 4'h4;

  typedef enum logic [1:0] {
    RES_OFF       = 2'h0,
    RES_INPUT_ONE = 2'h1,
    RES_INPUT_TWO = 2'h2,
    RES_DERIVED   = 2'h3
  } bfp_res_sel_t;

  typedef enum logic [2:0] {
    FORCE_NORMAL  = 3'h0,
    FORCE_START   = 3'h1,
    FORCE_RETRIP  = 3'h2,
    FORCE_BFAIL   = 3'h3,
    FORCE_BLOCKED = 3'h4
  } bfp_force_t;

  typedef enum logic [4:0] {
    ST_NORMAL  = 5'b00001,
    ST_START   = 5'b00010,
    ST_RETRIP  = 5'b00100,
    ST_BFAIL   = 5'b01000,
    ST_BLOCKED = 5'b10000
  } bfp_state_t;

  typedef struct packed {
    logic         group_sel;
    bfp_force_t   force_code;
    logic         force_en;
    logic         retrip_en;
    bfp_res_sel_t res_sel;
    logic [3:0]   mode;
  } bfp_ctrl_t;

  localparam bfp_ctrl_t CTRL_RST = '{1'b0, FORCE_NORMAL, 1'b0, 1'b1,
                                     RES_OFF, MODE_CUR_ONLY};

  typedef struct packed {
    logic [MAG_W-1:0] phase_pickup_threshold;
    logic [MAG_W-1:0] residual_pickup_threshold;
    logic [DLY_W-1:0] rt_dly;
    logic [DLY_W-1:0] bf_dly;
  } bfp_grp_t;

  localparam bfp_grp_t GRP_RST = '{PH_THR_RST, RES_THR_RST,
                                   RT_DLY_RST, BF_DLY_RST};

endpackage : bfp_pkg

// ---- logic/bfp_level_cmp.sv ----
// threshold comparator with built-in release hysteresis
`timescale 1ns/100ps
module bfp_level_cmp
  import bfp_pkg::*;
#(
  parameter int W = MAG_W
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_enable,
  input  wire logic [W-1:0] i_mag,
  input  wire logic [W-1:0] i_thr,
  output logic              o_pick
);

  localparam int PW = W + 7;

  logic [PW-1:0] mag_scaled;
  logic [PW-1:0] thr_scaled;

  assign mag_scaled = PW'(i_mag) * PW'(HYST_DEN);
  assign thr_scaled = PW'(i_thr) * PW'(HYST_NUM);

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_pick <= 1'b0;
    end else if (!i_enable) begin
      o_pick <= 1'b0;
    // RULE12 pick on exceed
    end else if (!o_pick && i_mag > i_thr) begin
      o_pick <= 1'b1;
    // RULE13 release below fraction
    end else if (o_pick && mag_scaled < thr_scaled) begin
      o_pick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  property p_cmp_pick;
    i_enable && !o_pick && i_mag > i_thr |=> o_pick;
  endproperty
  a_cmp_pick: assert property (p_cmp_pick) else $error("no pick-up on exceed"); // RULE12

  property p_cmp_hold;
    i_enable && o_pick && mag_scaled >= thr_scaled |=> o_pick;
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("early release"); // RULE13

endmodule : bfp_level_cmp

// ---- bench/bfp_far_side.sv ----
// far side model: measurement chain, protection stages and output relays
`timescale 1ns/100ps
module bfp_far_side
  import bfp_pkg::*;
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_resetn,
  input  wire logic [7:0]            i_lag,
  input  wire logic [2:0][MAG_W-1:0] i_mag_req,
  input  wire logic [2:0][MAG_W-1:0] i_res_req,
  input  wire logic [SIG_W-1:0]      i_sig_req,
  input  wire logic [DO_W-1:0]       i_do_req,
  output logic [2:0][MAG_W-1:0]      o_phase_mag,
  output logic [2:0][MAG_W-1:0]      o_res_mag,
  output logic [SIG_W-1:0]           o_trip_signals,
  output logic [DO_W-1:0]            o_relay_ctrl
);
  logic [7:0] wait_cnt;

  // new values appear once per lag window, prompt when lag is zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      wait_cnt       <= 8'h00;
      o_phase_mag    <= '0;
      o_res_mag      <= '0;
      o_trip_signals <= '0;
      o_relay_ctrl   <= '0;
    end else if (wait_cnt >= i_lag) begin
      wait_cnt       <= 8'h00;
      o_phase_mag    <= i_mag_req;
      o_res_mag      <= i_res_req;
      o_trip_signals <= i_sig_req;
      o_relay_ctrl   <= i_do_req;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule : bfp_far_side

// ---- bench/bfp_tb_top.sv ----
// self-checking bench of the breaker failure pick-up stage
`timescale 1ns/100ps
module bfp_tb_top;
  import bfp_pkg::*;
  localparam int unsigned STEPC = 4;
  logic clk, resetn, psel, pen, pwr, pready, pslverr, blk, grp, e;
  logic start, retrip, bfo, blocked;
  logic [AW-1:0]         paddr;
  logic [31:0]           pwdata, prdata, rd, seed, r;
  logic [2:0][MAG_W-1:0] mreq, rreq, mag, res;
  logic [SIG_W-1:0]      sreq, sig;
  logic [DO_W-1:0]       dreq, dout;
  logic [7:0]            lag;
  bfp_state_t            status;
  int                    fail_count, n_checks;

  bfp_far_side far (.i_sys_clk(clk), .i_resetn(resetn), .i_lag(lag), .i_mag_req(mreq),
    .i_res_req(rreq), .i_sig_req(sreq), .i_do_req(dreq), .o_phase_mag(mag),
    .o_res_mag(res), .o_trip_signals(sig), .o_relay_ctrl(dout));

  bfp_top #(.P_STEP_CYCLES(STEPC)) dut (.i_sys_clk(clk), .i_resetn(resetn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_phase_mag(mag), .i_residual_input_one(res[0]),
    .i_residual_input_two(res[1]), .i_derived_residual_current(res[2]),
    .i_trip_signals(sig), .i_relay_ctrl(dout), .i_block(blk), .i_group_sel(grp),
    .o_start(start), .o_retrip(retrip), .o_breaker_failure_output(bfo),
    .o_blocked(blocked), .o_status(status));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic f_pick(input logic [3:0] m, input logic c, s, d);
    logic [2:0] act;
    act = {d, s, c} & m[2:0];
    return m[3] ? (m[2:0] != 3'h0 && act == m[2:0]) : (act != 3'h0);
  endfunction : f_pick

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(e, 32'h0);
  endtask : rdchk

  task ctrl(input logic [3:0] m, input logic [1:0] s, input logic rt, fe, input logic [2:0] c);
    apb(1'b1, OFS_CTRL, {20'h0, 1'b0, c, fe, rt, s, m});
  endtask : ctrl

  task timed(input int drt, input int dbf, input logic rten);
    int n, trt, tbf;
    trt = -1;
    tbf = -1;
    for (n = 1; n < 400 && tbf < 0; n++) begin
      @(posedge clk);
      if (retrip === 1'b1 && trt < 0) trt = n;
      if (bfo === 1'b1) tbf = n;
    end
    check(rten ? (trt >= drt * STEPC && trt <= drt * STEPC + 8) : (trt < 0), 1);
    check(tbf >= dbf * STEPC && tbf <= dbf * STEPC + 8, 1);
  endtask : timed

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'd27015;
    {psel, pen, pwr, blk, grp} = 5'h0;
    paddr = '0;
    pwdata = '0;
    lag = 8'h00;
    mreq = '0;
    rreq = '0;
    sreq = '0;
    dreq = '0;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rdchk(OFS_CTRL, 32'h41);
    rdchk(8'h20, 32'd20);
    rdchk(8'h24, 32'd1200);
    rdchk(8'h28, 32'd20);
    rdchk(8'h2c, 32'd40);
    check(status, ST_NORMAL);
    apb(1'b0, 8'h14, 32'h0);
    check(e, 32'h1);
    r = rnd() % 3;
    mreq[r] <= 16'd199;
    repeat (8) @(posedge clk);
    check(start, 1'b0);
    apb(1'b1, 8'h28, 32'd3);
    apb(1'b1, 8'h2c, 32'd6);
    mreq[r] <= 16'd201;
    timed(3, 6, 1'b1);
    check(status, ST_BFAIL);
    mreq[r] <= 16'd195;
    repeat (8) @(posedge clk);
    check(bfo, 1'b1);
    mreq[r] <= 16'd193;
    repeat (8) @(posedge clk);
    check({start, retrip, bfo}, 3'h0);
    mreq[r] <= 16'd201;
    timed(3, 6, 1'b1);
    ctrl(4'h1, 2'h0, 1'b0, 1'b0, 3'h0);
    mreq <= '0;
    repeat (8) @(posedge clk);
    mreq[0] <= 16'd300;
    timed(3, 6, 1'b0);
    ctrl(4'h1, 2'h0, 1'b1, 1'b0, 3'h0);
    mreq[1] <= 16'd300;
    blk <= 1'b1;
    repeat (8) @(posedge clk);
    check({blocked, start, bfo}, 3'h4);
    check(status, ST_BLOCKED);
    rdchk(OFS_STATUS, 32'h1310);
    rdchk(OFS_TIMER, 32'h0);
    blk <= 1'b0;
    timed(3, 6, 1'b1);
    mreq <= '0;
    apb(1'b1, 8'h24, 32'd100);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 3; k++) begin
        lag <= 8'(k);
        ctrl(4'h1, 2'(s), 1'b1, 1'b0, 3'h0);
        rreq <= (3 * MAG_W)'(16'd150) << (MAG_W * k);
        repeat (10) @(posedge clk);
        check(start, s == k + 1);
      end
    end
    rreq <= '0;
    lag <= 8'h00;
    apb(1'b1, 8'h28, 32'd1000);
    apb(1'b1, 8'h2c, 32'd1000);
    for (int i = 0; i < 48; i++) begin
      logic [3:0] m;
      logic [15:0] sm;
      logic [7:0] dm;
      m = (i < 16) ? 4'(i) : 4'(rnd());
      sm = 16'(rnd());
      dm = 8'(rnd());
      r = rnd();
      apb(1'b1, OFS_SIG_MASK, {16'h0, sm});
      apb(1'b1, OFS_DO_MASK, {24'h0, dm});
      ctrl(m, 2'h0, 1'b1, 1'b0, 3'h0);
      mreq[2] <= r[0] ? 16'd300 : 16'd0;
      sreq <= r[31:16];
      dreq <= r[15:8];
      repeat (8) @(posedge clk);
      check(start, f_pick(m, r[0], |(r[31:16] & sm), |(r[15:8] & dm)));
    end
    for (int c = 0; c < 8; c++) begin
      ctrl(4'h1, 2'h0, 1'b1, 1'b1, 3'(c));
      repeat (4) @(posedge clk);
      check(status, (c < 5) ? (32'h1 << c) : 32'h1);
    end
    ctrl(4'h1, 2'h0, 1'b1, 1'b0, 3'h0);
    apb(1'b1, OFS_SIG_MASK, 32'h5a5a);
    apb(1'b1, 8'h30, 32'd50);
    mreq <= (3 * MAG_W)'(16'd300);
    repeat (8) @(posedge clk);
    check(start, 1'b1);
    grp <= 1'b1;
    repeat (8) @(posedge clk);
    check(start, 1'b0);
    rdchk(OFS_SIG_MASK, 32'h5a5a);
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule : bfp_tb_top
